// [design/ddp_params.svh]
// offsets, field positions and reset values of the dual data pointer unit
`ifndef DDP_PARAMS_SVH
`define DDP_PARAMS_SVH
`define DDP_CTRL_ADDR 8'h00_A7
`define DDP_LOW_ADDR 8'h00_82
`define DDP_HIGH_ADDR 8'h00_83
`define DDP_PAGE_ADDR 8'h00_84
`define DDP_CTRL_RESET 8'h00_00
`define DDP_PTR_RESET 24'h00_0000
`define DDP_SEL_BIT 0
`define DDP_UNIMPL_BIT 1
`define DDP_MAIN_MODE_LO 2
`define DDP_SHADOW_MODE_LO 4
`define DDP_SWAP_BIT 6
`define DDP_RSVD_BIT 7
`define DDP_CTRL_WMASK 8'h00_FD
`endif

// [design/ddp_pkg.sv]
// types shared by the dual data pointer unit
package ddp_pkg;
  // post-move action of a pointer
  typedef enum logic [1:0] {
    DDP_KEEP = 2'b00,
    DDP_INC = 2'b01,
    DDP_DEC = 2'b10,
    DDP_FLIP_LSB = 2'b11
  } ddp_mode_t;

  // special function register access from the core
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ddp_sfr_req_t;

  // pointer operations issued by the core
  typedef struct packed {
    logic move_done;     // code or external move addressed through the pointer finished
    logic load;          // other pointer op: load whole value
    logic inc;           // other pointer op: increment by one
    logic [23:0] value;
  } ddp_ptr_op_t;

  // pointer control register seen as fields
  typedef struct packed {
    logic reserved;
    logic auto_swap_enable;
    ddp_mode_t shadow_ptr_mode;
    ddp_mode_t main_ptr_mode;
    logic unimpl;
    logic pointer_select;
  } ddp_ctrl_t;
endpackage : ddp_pkg

// [design/ddp_dual_pointer.sv]
// dual data pointer unit: two 24-bit pointers and their control register
`timescale 1ns/100ps
`include "ddp_params.svh"

module ddp_dual_pointer (
  input wire logic clock,
  input wire logic srst,
  input wire ddp_pkg::ddp_sfr_req_t sfr_req,
  input wire ddp_pkg::ddp_ptr_op_t ptr_op,
  output logic [7:0] sfr_rdata,
  output logic [23:0] active_pointer,
  output logic pointer_select
);
  import ddp_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  // control register, bit 1 held at zero by the write mask
  ddp_ctrl_t ctrl_q, ctrl_d;
  // main pointer, page:high:low
  logic [23:0] main_ptr_q, main_ptr_d;
  // shadow pointer, same layout
  logic [23:0] shadow_ptr_q, shadow_ptr_d;
  // registered read data
  logic [7:0] rdata_q, rdata_d;
  // registered copy of the pointer now selected
  logic [23:0] active_q, active_d;
  // registered copy of the select bit
  logic sel_q, sel_d;

  // ************************************************************
  // helper functions
  // ************************************************************
  // byte lane of a pointer address, 3 when the address is no pointer byte
  // shared by write and read decode so both always agree
  function automatic logic [1:0] byte_lane(input logic [7:0] a);
    case (a)
      `DDP_LOW_ADDR: byte_lane = 2'd0;
      `DDP_HIGH_ADDR: byte_lane = 2'd1;
      `DDP_PAGE_ADDR: byte_lane = 2'd2;
      default: byte_lane = 2'd3;
    endcase
  endfunction : byte_lane

  // post-move action on one pointer
  function automatic logic [23:0] apply_mode(input logic [23:0] p, input ddp_mode_t m);
    case (m)
      DDP_INC: apply_mode = p + 24'h00_0001;
      DDP_DEC: apply_mode = p - 24'h00_0001;
      DDP_FLIP_LSB: apply_mode = {p[23:1], ~p[0]};
      default: apply_mode = p;
    endcase
  endfunction : apply_mode

  // byte lane write into a pointer
  function automatic logic [23:0] put_byte(input logic [23:0] p, input logic [1:0] lane,
                                           input logic [7:0] b);
    logic [23:0] r;
    r = p;
    case (lane)
      2'd0: r[7:0] = b;
      2'd1: r[15:8] = b;
      2'd2: r[23:16] = b;
      default: r = p;
    endcase
    put_byte = r;
  endfunction : put_byte

  // ************************************************************
  // pointer and control next-state logic
  // ************************************************************
  // same-cycle order: load or increment, byte write, mode action, swap
  // the pointer that moves is the one selected before this edge, so a
  // control write in the same cycle cannot redirect the action
  // moves through the program counter or a working register never reach
  // this block, the core keeps move_done low for them
  always_comb begin
    logic [23:0] act;
    logic [23:0] nxt;
    logic [1:0] lane;
    logic hit;
    act = 24'h00_0000;
    nxt = 24'h00_0000;
    lane = 2'd3;
    hit = 1'b0;
    ctrl_d = ctrl_q;
    main_ptr_d = main_ptr_q;
    shadow_ptr_d = shadow_ptr_q;
    act = ctrl_q.pointer_select ? shadow_ptr_q : main_ptr_q;
    nxt = act;
    // other ops change active pointer only
    if (ptr_op.load) begin
      nxt = ptr_op.value;
    end else if (ptr_op.inc) begin
      nxt = act + 24'h00_0001;
    end
    // register byte writes into the active pointer
    // writes to unmapped addresses fall through and change nothing
    lane = byte_lane(sfr_req.addr);
    hit = sfr_req.wr && (lane != 2'd3);
    // bit 1 never stored, bit 7 has no use
    if (sfr_req.wr && (sfr_req.addr == `DDP_CTRL_ADDR)) begin
      ctrl_d = ddp_ctrl_t'(sfr_req.wdata & `DDP_CTRL_WMASK);
    end
    // byte write lands after a load or increment of the same cycle
    if (hit) begin
      nxt = put_byte(nxt, lane, sfr_req.wdata);
    end
    // only pointer-addressed moves arrive as move_done
    if (ptr_op.move_done) begin
      nxt = apply_mode(nxt, ctrl_q.pointer_select ? ctrl_q.shadow_ptr_mode
                                                  : ctrl_q.main_ptr_mode);
      if (ctrl_q.auto_swap_enable) begin
        ctrl_d.pointer_select = ~ctrl_d.pointer_select;
      end
    end
    if (ctrl_q.pointer_select) begin
      shadow_ptr_d = nxt;
    end else begin
      main_ptr_d = nxt;
    end
  end

  // ************************************************************
  // output and read data next-state logic
  // ************************************************************
  // outputs follow the next state so they match the stored values
  always_comb begin
    active_d = ctrl_d.pointer_select ? shadow_ptr_d : main_ptr_d;
    sel_d = ctrl_d.pointer_select;
  end

  // read data of the addressed byte, state before any same-cycle write
  // a read in the cycle of a write thus returns the old byte
  always_comb begin
    logic [23:0] cur;
    cur = 24'h00_0000;
    cur = ctrl_q.pointer_select ? shadow_ptr_q : main_ptr_q;
    rdata_d = 8'h00_00;
    if (sfr_req.addr == `DDP_CTRL_ADDR) begin
      rdata_d = ctrl_q;
    end else begin
      // unmapped addresses read as zero
      case (byte_lane(sfr_req.addr))
        2'd0: rdata_d = cur[7:0];
        2'd1: rdata_d = cur[15:8];
        2'd2: rdata_d = cur[23:16];
        default: rdata_d = 8'h00_00;
      endcase
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  // control register
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_q <= ddp_ctrl_t'(`DDP_CTRL_RESET);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // both pointers, the inactive one only reloads its own value
  always_ff @(posedge clock) begin
    if (srst) begin
      main_ptr_q <= `DDP_PTR_RESET;
      shadow_ptr_q <= `DDP_PTR_RESET;
    end else begin
      main_ptr_q <= main_ptr_d;
      shadow_ptr_q <= shadow_ptr_d;
    end
  end

  // output copies, registered so every port leaves a flip-flop
  // costs a few extra registers but keeps port timing clean
  // select copy resets to zero like the control register
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_q <= 8'h00_00;
      active_q <= `DDP_PTR_RESET;
      sel_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      active_q <= active_d;
      sel_q <= sel_d;
    end
  end

  // ************************************************************
  // ports
  // ************************************************************
  // ports come straight from the output copies
  assign sfr_rdata = rdata_q;
  assign active_pointer = active_q;
  assign pointer_select = sel_q;
endmodule : ddp_dual_pointer

// [verification/ddp_props.sv]
// checker for the dual data pointer unit
`timescale 1ns/100ps
module ddp_props (
  input wire logic clock,
  input wire logic srst,
  input wire ddp_pkg::ddp_sfr_req_t sfr_req,
  input wire ddp_pkg::ddp_ptr_op_t ptr_op,
  input wire logic [7:0] sfr_rdata,
  input wire logic [23:0] active_pointer,
  input wire logic pointer_select
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  wire ctl = sfr_req.addr == 8'hA7;
  wire nw = !sfr_req.wr && !ptr_op.move_done;
  wire idle = nw && !ptr_op.load && !ptr_op.inc;
  // control write, a quiet cycle, then a bare move
  sequence arm(b);
    sfr_req.wr && ctl && !ptr_op.move_done && sfr_req.wdata[6] == b ##1 idle
      ##1 ptr_op.move_done && !sfr_req.wr;
  endsequence
  AST_HOLD: assert property (idle |=> $stable({active_pointer, pointer_select}))
    else $error("pointer moved");
  AST_LOAD: assert property (ptr_op.load && !ptr_op.inc && nw |=>
    active_pointer == $past(ptr_op.value)) else $error("load");
  AST_INC: assert property (ptr_op.inc && !ptr_op.load && nw |=>
    active_pointer == $past(active_pointer) + 24'h1) else $error("inc");
  AST_SEL: assert property (sfr_req.wr && ctl && !ptr_op.move_done |=>
    pointer_select == $past(sfr_req.wdata[0])) else $error("select");
  AST_CTRL: assert property (ctl |=> sfr_rdata[1:0] == {1'b0, $past(pointer_select)})
    else $error("ctrl read");
  AST_LOW: assert property (sfr_req.addr == 8'h82 |=>
    sfr_rdata == $past(active_pointer[7:0])) else $error("low read");
  AST_SWAP: assert property (arm(1'b1) |=> pointer_select != $past(pointer_select))
    else $error("no swap");
  AST_KEEP: assert property (arm(1'b0) |=> $stable(pointer_select))
    else $error("swap");
endmodule : ddp_props
bind ddp_dual_pointer ddp_props ddp_props_i (.*);

// [verification/ddp_core.sv]
// core model driving the unit's request ports
`timescale 1ns/100ps
module ddp_core (
  input wire logic clock,
  output ddp_pkg::ddp_sfr_req_t sfr_req,
  output ddp_pkg::ddp_ptr_op_t ptr_op,
  input wire logic [7:0] sfr_rdata
);
  import ddp_pkg::*;
  logic [7:0] d;
  initial {sfr_req, ptr_op} = '0;
  // one-cycle request; released data lines show the inverse, not stale values
  task automatic go(ddp_sfr_req_t q, ddp_ptr_op_t o);
    @(posedge clock);
    #1 {sfr_req, ptr_op} = {q, o};
    @(posedge clock);
    #1 d = sfr_rdata;
    {sfr_req, ptr_op} = {1'b0, q.addr, ~q.wdata, 3'b000, ~o.value};
  endtask : go
endmodule : ddp_core

// [verification/ddp_dual_pointer_bench.sv]
// self-checking bench for the dual data pointer unit
`timescale 1ns/100ps
module ddp_dual_pointer_bench;
  import ddp_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  ddp_sfr_req_t sfr_req;
  ddp_ptr_op_t ptr_op;
  logic [7:0] sfr_rdata, c;
  logic [23:0] active_pointer, v, e;
  logic pointer_select;
  int miscompares, comparisons;
  ddp_dual_pointer ddp_dual_pointer_i (.*);
  ddp_core ddp_core_i (.*);
  initial forever #5 clock = ~clock;
  task automatic end_sim();
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic chk(string n, logic [23:0] x, logic [23:0] g);
    comparisons++;
    if (g !== x) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task automatic w(logic a, logic [7:0] b, logic [7:0] d);
    ddp_core_i.go({a, b, d}, '0);
  endtask : w
  task automatic rd(logic [7:0] a, logic [7:0] x);
    w(1'b0, a, 8'h00);
    chk("read", {16'h0, x}, {16'h0, ddp_core_i.d});
  endtask : rd
  task automatic op(logic [2:0] k, logic [23:0] x);
    ddp_core_i.go('0, {k, x});
  endtask : op
  initial begin
    #20000;
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clock);
    #1 srst = 1'b0;
    rd(8'hA7, 8'h00);
    w(1'b1, 8'hA7, 8'hFF);
    rd(8'hA7, 8'hFD);
    w(1'b1, 8'hA7, 8'h00);
    for (int i = 0; i < 3; i++) w(1'b1, 8'h82 + 8'(i), 8'h21 + 8'(i));
    chk("ptr", 24'h23_2221, active_pointer);
    rd(8'h83, 8'h22);
    rd(8'h84, 8'h23);
    // every mode on both pointers, reserved bit set
    for (int i = 0; i < 8; i++) begin
      v = i[2:1] == 1 ? '1 : i[2:1] == 2 ? '0 : 24'h12_3456;
      e = i[2:1] == 0 ? v : i[2:1] == 1 ? v + 24'h1 : i[2:1] == 2 ? v - 24'h1 : v ^ 24'h1;
      c = {2'b10, i[0] ? i[2:1] : ~i[2:1], i[0] ? ~i[2:1] : i[2:1], 1'b0, i[0]};
      w(1'b1, 8'hA7, c);
      op(3'b010, v);
      w(1'b1, 8'hA7, c);
      op(3'b100, 24'h0);
      chk("mode", e, active_pointer);
      chk("sel", 24'(i[0]), 24'(pointer_select));
    end
    w(1'b1, 8'hA7, 8'h00);
    op(3'b010, 24'h00_0010);
    w(1'b1, 8'hA7, 8'h01);
    op(3'b010, 24'h00_D000);
    w(1'b1, 8'hA7, 8'h55);
    op(3'b100, 24'h0);
    chk("swap", 24'h00_0010, active_pointer);
    op(3'b100, 24'h0);
    chk("swap", 24'h00_D001, active_pointer);
    op(3'b100, 24'h0);
    op(3'b001, 24'h0);
    chk("swap", 24'h00_0012, active_pointer);
    rd(8'h00, 8'h00);
    end_sim();
  end
endmodule : ddp_dual_pointer_bench
